// File: mie_pkg.sv
// Shared constants, opcodes and helper functions of the instruction execution core.
package mie_pkg;
	localparam int             DW            = 8;
	localparam int             PAW           = 11;
	localparam int             IW            = 18;
	localparam int             OP_MSB        = 17;
	localparam int             OP_LSB        = 12;
	localparam int             BIT_MSB       = 10;
	localparam int             BIT_LSB       = 8;
	localparam int             OPND_MSB      = 7;
	localparam int             TGT_MSB       = 10;
	localparam int             STACK_DEPTH   = 8;
	localparam int             SPW           = 3;
	localparam int             CLKS_PER_ICYC = 4;
	localparam logic [1:0]     PH_FIRST      = 2'h0;
	localparam logic [1:0]     PH_FETCH      = 2'h1;
	localparam logic [1:0]     PH_EXEC       = 2'(CLKS_PER_ICYC - 1);
	localparam logic [1:0]     PH_ONE        = 2'h1;
	localparam logic [7:0]     PCL_ADDR      = 8'h02;
	localparam logic [2:0]     TBL_PAGE      = 3'h7;
	localparam logic [7:0]     BYTE_ZERO     = 8'h00;
	localparam logic [7:0]     BYTE_ONE      = 8'h01;
	localparam logic [7:0]     BCD_LO        = 8'h06;
	localparam logic [7:0]     BCD_HI        = 8'h60;
	localparam logic [3:0]     NIB_MAX       = 4'h9;
	localparam logic [PAW-1:0] PC_RESET      = 11'h000;
	localparam logic [PAW-1:0] PC_ONE        = 11'h001;
	localparam logic [PAW-1:0] PC_TWO        = 11'h002;
	localparam logic [SPW-1:0] SP_RESET      = 3'h0;
	localparam logic [SPW-1:0] SP_ONE        = 3'h1;
	localparam int             NFLAGS        = 5;
	localparam int             FZ            = 0;
	localparam int             FC            = 1;
	localparam int             FHC           = 2;
	localparam int             FSRF          = 3;
	localparam int             FSEC          = 4;
	localparam logic [4:0]     FLAGS_RESET   = 5'h00;

	typedef enum logic [5:0] {
		OP_NOP, OP_LOAD_W, OP_STORE_W, OP_LOAD_IMM, OP_ADD_W, OP_SUM_MEM, OP_ADD_IMM,
		OP_SUMC_W, OP_SUMC_MEM, OP_SUB_W, OP_SUB_MEM, OP_SUB_IMM, OP_SUBB_W, OP_SUBB_MEM,
		OP_BCD_ADJ, OP_STEP_UP, OP_STEP_UP_W, OP_STEP_DN, OP_STEP_DN_W, OP_AND_W,
		OP_AND_IMM, OP_OR_W, OP_OR_IMM, OP_XOR_W, OP_XOR_IMM, OP_COMPL, OP_COMPL_W,
		OP_TURN_R, OP_TURN_L, OP_TURN_RC, OP_TURN_LC, OP_BIT_RAISE, OP_BIT_LOWER,
		OP_SKIP_Z, OP_SKIP_BZ, OP_SKIP_BNZ, OP_GOTO, OP_SUB_ENTRY, OP_SUB_EXIT,
		OP_TBL_RD, OP_PWR_DOWN, OP_WDT_CLEAR
	} mie_op_t;

	typedef enum logic [1:0] {ST_RUN, ST_FILL, ST_SLEEP} mie_state_t;

	function automatic mie_op_t f_op(input logic [IW-1:0] ins);
		return mie_op_t'(ins[OP_MSB:OP_LSB]);
	endfunction : f_op

	function automatic logic f_two_cycle(input mie_op_t op);
		return op inside {OP_GOTO, OP_SUB_ENTRY, OP_SUB_EXIT, OP_TBL_RD};
	endfunction : f_two_cycle

	function automatic logic f_is_imm(input mie_op_t op);
		return op inside {OP_LOAD_IMM, OP_ADD_IMM, OP_SUB_IMM, OP_AND_IMM, OP_OR_IMM,
			OP_XOR_IMM};
	endfunction : f_is_imm
endpackage : mie_pkg

// File: mie_alu_if.sv
// Bundle between the sequencer and the arithmetic and logic unit.
interface mie_alu_if;
	import mie_pkg::*;
	mie_op_t     op;
	logic [7:0]  wreg;
	logic [7:0]  opnd;
	logic [2:0]  bit_sel;
	logic [4:0]  flags_in;
	logic [7:0]  result;
	logic [4:0]  flags_out;
	logic        to_mem;
	logic        to_w;
	logic        skip;
	modport core (output op, wreg, opnd, bit_sel, flags_in,
		input result, flags_out, to_mem, to_w, skip);
	modport alu (input op, wreg, opnd, bit_sel, flags_in,
		output result, flags_out, to_mem, to_w, skip);
endinterface : mie_alu_if

// File: mie_dmem.sv
// Data memory sector 0 with a registered read port.
module mie_dmem (
	input  wire logic       clk_i,
	input  wire logic       we_i,
	input  wire logic [7:0] waddr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic [7:0] raddr_i,
	output logic      [7:0] rdata_o
);
	logic [7:0] mem_ff [256];
	logic [7:0] rdata_ff;

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem_ff[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		rdata_ff <= mem_ff[raddr_i];
	end

	assign rdata_o = rdata_ff;
endmodule : mie_dmem

// File: mie_alu.sv
// Combinational arithmetic, logic, rotate, bit and test unit.
module mie_alu (
	mie_alu_if.alu bus
);
	import mie_pkg::*;
	logic [7:0] b;
	logic [7:0] bx;
	logic [7:0] mask;
	logic       cin;
	logic       sub;
	logic       arith;
	logic       set_z;
	logic [8:0] sum;
	logic [4:0] half;
	logic [7:0] lo_fix;
	logic [8:0] d1;
	logic       hi_need;
	logic [8:0] d2;
	logic [7:0] res;
	logic [4:0] fl;
	logic       to_mem;
	logic       to_w;
	logic       skip;

	assign b = bus.opnd;
	assign mask = BYTE_ONE << bus.bit_sel;
	assign bx = sub ? ~b : b;
	assign sum = {1'b0, bus.wreg} + {1'b0, bx} + {8'h00, cin};
	assign half = {1'b0, bus.wreg[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
	assign lo_fix = (bus.wreg[3:0] > NIB_MAX || bus.flags_in[FHC]) ? BCD_LO : BYTE_ZERO;
	assign d1 = {1'b0, bus.wreg} + {1'b0, lo_fix};
	assign hi_need = d1[8] | (d1[7:4] > NIB_MAX) | bus.flags_in[FC];
	assign d2 = d1 + {1'b0, (hi_need ? BCD_HI : BYTE_ZERO)};

	always_comb begin
		cin = 1'b0;
		sub = 1'b0;
		arith = 1'b0;
		set_z = 1'b0;
		to_mem = 1'b0;
		to_w = 1'b0;
		skip = 1'b0;
		case (bus.op)
			OP_ADD_W, OP_ADD_IMM, OP_SUM_MEM: begin
				arith = 1'b1;
			end
			OP_SUMC_W, OP_SUMC_MEM: begin
				arith = 1'b1;
				cin = bus.flags_in[FC];
			end
			OP_SUB_W, OP_SUB_IMM, OP_SUB_MEM: begin
				arith = 1'b1;
				sub = 1'b1;
				cin = 1'b1;
			end
			OP_SUBB_W, OP_SUBB_MEM: begin
				arith = 1'b1;
				sub = 1'b1;
				cin = bus.flags_in[FC];
			end
			OP_STEP_UP, OP_STEP_UP_W, OP_STEP_DN, OP_STEP_DN_W, OP_AND_W, OP_AND_IMM,
			OP_OR_W, OP_OR_IMM, OP_XOR_W, OP_XOR_IMM, OP_COMPL, OP_COMPL_W: begin
				set_z = 1'b1;
			end
			OP_SKIP_Z: begin
				skip = (b == BYTE_ZERO);
			end
			OP_SKIP_BZ: begin
				skip = ~b[bus.bit_sel];
			end
			OP_SKIP_BNZ: begin
				skip = b[bus.bit_sel];
			end
			default: begin
			end
		endcase
		to_w = bus.op inside {OP_LOAD_W, OP_LOAD_IMM, OP_ADD_W, OP_ADD_IMM, OP_SUMC_W,
			OP_SUB_W, OP_SUB_IMM, OP_SUBB_W, OP_STEP_UP_W, OP_STEP_DN_W, OP_AND_W,
			OP_AND_IMM, OP_OR_W, OP_OR_IMM, OP_XOR_W, OP_XOR_IMM, OP_COMPL_W};
		to_mem = bus.op inside {OP_STORE_W, OP_SUM_MEM, OP_SUMC_MEM, OP_SUB_MEM,
			OP_SUBB_MEM, OP_BCD_ADJ, OP_STEP_UP, OP_STEP_DN, OP_COMPL, OP_TURN_R,
			OP_TURN_L, OP_TURN_RC, OP_TURN_LC, OP_BIT_RAISE, OP_BIT_LOWER};
	end

	always_comb begin
		res = b;
		fl = bus.flags_in;
		case (bus.op)
			OP_STORE_W: res = bus.wreg;
			OP_STEP_UP, OP_STEP_UP_W: res = b + BYTE_ONE;
			OP_STEP_DN, OP_STEP_DN_W: res = b - BYTE_ONE;
			OP_AND_W, OP_AND_IMM: res = bus.wreg & b;
			OP_OR_W, OP_OR_IMM: res = bus.wreg | b;
			OP_XOR_W, OP_XOR_IMM: res = bus.wreg ^ b;
			OP_COMPL, OP_COMPL_W: res = ~b;
			OP_TURN_R: res = {b[0], b[7:1]};
			OP_TURN_L: res = {b[6:0], b[7]};
			OP_TURN_RC: begin
				res = {bus.flags_in[FC], b[7:1]};
				fl[FC] = b[0];
			end
			OP_TURN_LC: begin
				res = {b[6:0], bus.flags_in[FC]};
				fl[FC] = b[7];
			end
			OP_BIT_RAISE: res = b | mask;
			OP_BIT_LOWER: res = b & ~mask;
			OP_BCD_ADJ: begin
				res = d2[7:0];
				fl[FC] = hi_need;
			end
			default: begin
			end
		endcase
		if (arith) begin
			res = sum[7:0];
			fl[FC] = sum[8];
			fl[FHC] = half[4];
			fl[FSRF] = (bus.wreg[7] == bx[7]) && (sum[7] != bus.wreg[7]);
			fl[FSEC] = sum[7] ^ fl[FSRF];
			fl[FZ] = (sum[7:0] == BYTE_ZERO);
		end else if (set_z) begin
			fl[FZ] = (res == BYTE_ZERO);
		end
	end

	assign bus.result = res;
	assign bus.flags_out = fl;
	assign bus.to_mem = to_mem;
	assign bus.to_w = to_w;
	assign bus.skip = skip;
endmodule : mie_alu

// File: mie_core.sv
// Instruction sequencer and execution core of the 8-bit microcontroller.
// Behaviour
// - Add memory or immediate to working register, optional carry, update five flags.
// - Subtract memory or immediate, optional borrow, update five flags.
// - Eight bit datapath; carry out above 255, borrow below zero.
// - Step up or down by one; working variants write the working register.
// - Logic operations pass through working register and set zero on zero.
// - Rotates move one bit; carry variants route the outgoing bit into carry.
// - Bit raise or lower changes one bit of a byte, others kept.
// - Subroutine entry saves return point; exit resumes after the entry.
// - Goto loads the program counter and saves no return address.
// - Conditional tests of byte or bit skip or continue.
// - Table read fetches fixed data from a program memory area.
// - Power down instruction sleeps the core; separate watchdog clear instruction.
// - Direct data memory access addresses sector 0 only.
// - Packed decimal adjust of working register written to memory.
// - Instruction cycle is four clocks; most instructions take one.
// - Branch, entry, exit and table read take two instruction cycles.
// - Writing the program counter low byte adds one instruction cycle.
// - A taken skip adds one instruction cycle; untaken costs one.
module mie_core (
	input  wire logic                    SYS_CLK_I,
	input  wire logic                    RESETN_I,
	input  wire logic [mie_pkg::IW-1:0]  PROG_DATA_I,
	input  wire logic                    WAKE_I,
	output logic      [mie_pkg::PAW-1:0] PROG_ADDR_O,
	output logic      [7:0]              WORK_REG_O,
	output logic                         ZERO_FLAG_O,
	output logic                         CARRY_FLAG_O,
	output logic                         HALF_CARRY_FLAG_O,
	output logic                         SIGNED_RANGE_FLAG_O,
	output logic                         SECONDARY_RESULT_FLAG_O,
	output logic                         POWER_DOWN_O,
	output logic                         WDT_CLEAR_O,
	output logic                         MEM_WE_O,
	output logic      [7:0]              MEM_WADDR_O,
	output logic      [7:0]              MEM_WDATA_O,
	output logic                         INSTR_DONE_O
);
	import mie_pkg::*;

	logic [1:0]     phase_ff;
	mie_state_t     st_ff;
	mie_state_t     nxt_st;
	logic [IW-1:0]  instr_ff;
	logic [PAW-1:0] pc_ff;
	logic [PAW-1:0] nxt_pc;
	logic [PAW-1:0] prog_addr_ff;
	logic [7:0]     w_ff;
	logic [4:0]     flags_ff;
	logic [PAW-1:0] stack_ff [STACK_DEPTH];
	logic [SPW-1:0] sp_ff;
	logic           tbl_pend_ff;
	logic [7:0]     tbl_dst_ff;
	logic [7:0]     tbl_data_ff;
	logic           pd_ff;
	logic           wdt_ff;
	logic           mwe_ff;
	logic [7:0]     mwaddr_ff;
	logic [7:0]     mwdata_ff;
	logic           done_ff;

	mie_op_t        op;
	logic           exec;
	logic           fill_end;
	logic [7:0]     maddr;
	logic [7:0]     mem_rd;
	logic [7:0]     rd_val;
	logic [PAW-1:0] pc_inc;
	logic [PAW-1:0] pc_skip;
	logic [PAW-1:0] jmp_tgt;
	logic [PAW-1:0] stk_top;
	logic           pcl_write;
	logic           extra;
	logic           dm_we;
	logic [7:0]     dm_waddr;
	logic [7:0]     dm_wdata;

	mie_alu_if alu_bus ();

	mie_alu u_alu (
		.bus (alu_bus.alu)
	);

	mie_dmem u_dmem (
		.clk_i   (SYS_CLK_I),
		.we_i    (dm_we),
		.waddr_i (dm_waddr),
		.wdata_i (dm_wdata),
		.raddr_i (maddr),
		.rdata_o (mem_rd)
	);

	assign op = f_op(instr_ff);
	assign exec = (st_ff == ST_RUN) && (phase_ff == PH_EXEC);
	assign fill_end = (st_ff == ST_FILL) && (phase_ff == PH_EXEC);
	assign maddr = instr_ff[OPND_MSB:0];
	// Reading the low program counter byte sees the address of the current instruction.
	assign rd_val = (maddr == PCL_ADDR) ? pc_ff[OPND_MSB:0] : mem_rd;
	assign pc_inc = pc_ff + PC_ONE;
	assign pc_skip = pc_ff + PC_TWO;
	assign jmp_tgt = instr_ff[TGT_MSB:0];
	assign stk_top = stack_ff[sp_ff - SP_ONE];

	assign alu_bus.op = op;
	assign alu_bus.wreg = w_ff;
	assign alu_bus.opnd = f_is_imm(op) ? maddr : rd_val;
	assign alu_bus.bit_sel = instr_ff[BIT_MSB:BIT_LSB];
	assign alu_bus.flags_in = flags_ff;

	assign pcl_write = alu_bus.to_mem && (maddr == PCL_ADDR);
	assign extra = f_two_cycle(op) || alu_bus.skip || pcl_write;

	assign dm_we = (exec && alu_bus.to_mem && !pcl_write) || (fill_end && tbl_pend_ff);
	assign dm_waddr = fill_end ? tbl_dst_ff : maddr;
	assign dm_wdata = fill_end ? tbl_data_ff : alu_bus.result;

	always_comb begin
		case (op)
			OP_GOTO: nxt_pc = jmp_tgt;
			OP_SUB_ENTRY: nxt_pc = jmp_tgt;
			OP_SUB_EXIT: nxt_pc = stk_top;
			default: begin
				if (alu_bus.skip) begin
					nxt_pc = pc_skip;
				end else if (pcl_write) begin
					nxt_pc = {pc_ff[PAW-1:OPND_MSB+1], alu_bus.result};
				end else begin
					nxt_pc = pc_inc;
				end
			end
		endcase
	end

	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			ST_RUN: begin
				if (exec && op == OP_PWR_DOWN) begin
					nxt_st = ST_SLEEP;
				end else if (exec && extra) begin
					nxt_st = ST_FILL;
				end
			end
			ST_FILL: begin
				if (fill_end) begin
					nxt_st = ST_RUN;
				end
			end
			ST_SLEEP: begin
				if (phase_ff == PH_EXEC && WAKE_I) begin
					nxt_st = ST_RUN;
				end
			end
			default: nxt_st = ST_RUN;
		endcase
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin
			phase_ff <= PH_FIRST;
		end else begin
			phase_ff <= phase_ff + PH_ONE;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin
			st_ff <= ST_RUN;
			pd_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			pd_ff <= (nxt_st == ST_SLEEP);
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin
			instr_ff <= '0;
		end else if (st_ff == ST_RUN && phase_ff == PH_FETCH) begin
			instr_ff <= PROG_DATA_I;
		end
	end

	// The fetch address is moved only at the end of an instruction cycle, so it holds
	// steady for all four clocks and memory has two clocks to answer.
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin
			pc_ff <= PC_RESET;
			prog_addr_ff <= PC_RESET;
		end else if (exec) begin
			pc_ff <= nxt_pc;
			prog_addr_ff <= (op == OP_TBL_RD) ? {TBL_PAGE, w_ff} : nxt_pc;
		end else if (fill_end) begin
			prog_addr_ff <= pc_ff;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin
			w_ff <= BYTE_ZERO;
			flags_ff <= FLAGS_RESET;
		end else if (exec) begin
			if (alu_bus.to_w) begin
				w_ff <= alu_bus.result;
			end
			flags_ff <= alu_bus.flags_out;
		end
	end

	// The stack wraps when it overflows; software must keep calls within its depth.
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin
			sp_ff <= SP_RESET;
		end else if (exec && op == OP_SUB_ENTRY) begin
			stack_ff[sp_ff] <= pc_inc;
			sp_ff <= sp_ff + SP_ONE;
		end else if (exec && op == OP_SUB_EXIT) begin
			sp_ff <= sp_ff - SP_ONE;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin
			tbl_pend_ff <= 1'b0;
			tbl_dst_ff <= BYTE_ZERO;
			tbl_data_ff <= BYTE_ZERO;
		end else begin
			if (exec && op == OP_TBL_RD) begin
				tbl_pend_ff <= 1'b1;
				tbl_dst_ff <= maddr;
			end else if (fill_end) begin
				tbl_pend_ff <= 1'b0;
			end
			if (st_ff == ST_FILL && tbl_pend_ff && phase_ff == PH_FETCH) begin
				tbl_data_ff <= PROG_DATA_I[OPND_MSB:0];
			end
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin
			wdt_ff <= 1'b0;
			mwe_ff <= 1'b0;
			mwaddr_ff <= BYTE_ZERO;
			mwdata_ff <= BYTE_ZERO;
			done_ff <= 1'b0;
		end else begin
			wdt_ff <= exec && (op == OP_WDT_CLEAR);
			mwe_ff <= dm_we;
			mwaddr_ff <= dm_waddr;
			mwdata_ff <= dm_wdata;
			done_ff <= (exec && !extra && op != OP_PWR_DOWN) || fill_end;
		end
	end

	assign PROG_ADDR_O = prog_addr_ff;
	assign WORK_REG_O = w_ff;
	assign ZERO_FLAG_O = flags_ff[FZ];
	assign CARRY_FLAG_O = flags_ff[FC];
	assign HALF_CARRY_FLAG_O = flags_ff[FHC];
	assign SIGNED_RANGE_FLAG_O = flags_ff[FSRF];
	assign SECONDARY_RESULT_FLAG_O = flags_ff[FSEC];
	assign POWER_DOWN_O = pd_ff;
	assign WDT_CLEAR_O = wdt_ff;
	assign MEM_WE_O = mwe_ff;
	assign MEM_WADDR_O = mwaddr_ff;
	assign MEM_WDATA_O = mwdata_ff;
	assign INSTR_DONE_O = done_ff;

	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RESETN_I);

	sequence s_run_cycle;
		(st_ff == ST_RUN)[*4];
	endsequence

	sequence s_fill_cycle;
		(st_ff == ST_FILL)[*4];
	endsequence

	a_one_cycle_op: assert property (
		exec && !extra && op != OP_PWR_DOWN |=> s_run_cycle)
		else $error("single cycle instruction did not stay in run for four clocks");

	a_two_cycle_op: assert property (
		exec && f_two_cycle(op) |=> s_fill_cycle ##1 st_ff == ST_RUN)
		else $error("two cycle instruction did not take one extra cycle");

	a_goto_target: assert property (
		exec && op == OP_GOTO |=> pc_ff == $past(jmp_tgt) && sp_ff == $past(sp_ff))
		else $error("goto went to the wrong address or touched the stack");

	a_entry_saves: assert property (
		exec && op == OP_SUB_ENTRY |=> stk_top == $past(pc_inc) && pc_ff == $past(jmp_tgt))
		else $error("subroutine entry saved a wrong return point");

	a_exit_resume: assert property (
		exec && op == OP_SUB_EXIT |=> pc_ff == $past(stk_top) ##0 s_fill_cycle)
		else $error("subroutine exit resumed at a wrong address");

	a_skip_taken: assert property (
		exec && alu_bus.skip |=> pc_ff == $past(pc_skip) ##0 s_fill_cycle)
		else $error("taken skip did not pass over one instruction in two cycles");

	a_low_byte_jump: assert property (
		exec && pcl_write |=> st_ff == ST_FILL && !MEM_WE_O)
		else $error("write to program counter low byte lacked the extra cycle");

	a_bit_only_one: assert property (
		exec && (op == OP_BIT_RAISE || op == OP_BIT_LOWER) && !pcl_write
		|=> MEM_WE_O && $onehot0(MEM_WDATA_O ^ $past(rd_val)))
		else $error("bit operation changed more than one bit");

	a_add_carry_out: assert property (
		exec && op == OP_ADD_W |=>
		CARRY_FLAG_O == (({1'b0, $past(w_ff)} + {1'b0, $past(rd_val)}) > 9'h0FF))
		else $error("addition carry out wrong");

	a_logic_zero: assert property (
		exec && op inside {OP_AND_W, OP_OR_W, OP_XOR_W} |=>
		ZERO_FLAG_O == (WORK_REG_O == BYTE_ZERO))
		else $error("logic operation zero flag disagrees with result");

	a_power_down: assert property (
		exec && op == OP_PWR_DOWN |=> POWER_DOWN_O [*4])
		else $error("power down did not hold for a full cycle");
endmodule : mie_core

// File: tb_top.sv
// Self-checking testbench of the instruction execution core with a reference model.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import mie_pkg::*;

	logic        clk;
	logic        rst_n;
	logic        wake;
	logic [17:0] prog_data;
	logic [10:0] prog_addr;
	logic [7:0]  work_reg, mem_waddr, mem_wdata;
	logic        fz_o, fc_o, fhc_o, fsr_o, fsec_o, pwr_dn, wdt_clr, mem_we, done;
	logic [17:0] prog [0:2047];
	int          dm [0:255];
	int          stk [$];
	int          mismatches, checks_done, pa, w, mpc, npc, cyc, ma, md, we, seed, n, first;
	int          fz, fc, fhc, fsr, fsec;
	logic [17:0] ins;

	mie_core i_dut (
		.SYS_CLK_I(clk), .RESETN_I(rst_n), .PROG_DATA_I(prog_data), .WAKE_I(wake),
		.PROG_ADDR_O(prog_addr), .WORK_REG_O(work_reg), .ZERO_FLAG_O(fz_o),
		.CARRY_FLAG_O(fc_o), .HALF_CARRY_FLAG_O(fhc_o), .SIGNED_RANGE_FLAG_O(fsr_o),
		.SECONDARY_RESULT_FLAG_O(fsec_o), .POWER_DOWN_O(pwr_dn), .WDT_CLEAR_O(wdt_clr),
		.MEM_WE_O(mem_we), .MEM_WADDR_O(mem_waddr), .MEM_WDATA_O(mem_wdata),
		.INSTR_DONE_O(done)
	);

	initial forever #25 clk = ~clk;

	// Program memory answers one clock after the address, well inside the fetch window.
	always @(posedge clk) prog_data <= prog[prog_addr];

	function automatic int rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic put(input mie_op_t o, input int x);
		prog[pa] = {o, 12'(x)};
		pa++;
	endtask : put

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : check

	task automatic stop_test();
		$display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : stop_test

	function automatic int add(input int a, input int b, input int ci);
		int s;
		s = a + b + ci;
		fz = ((s & 255) == 0);
		fc = (s >> 8) & 1;
		fhc = ((a & 15) + (b & 15) + ci) > 15;
		fsr = ((a ^ s) & (b ^ s) & 128) != 0;
		fsec = fsr ^ ((s >> 7) & 1);
		return s & 255;
	endfunction : add

	task automatic model(input logic [17:0] i);
		mie_op_t o;
		int      m, v, b, r;
		o = mie_op_t'(i[17:12]);
		m = i[7:0];
		b = i[10:8];
		v = (o inside {OP_LOAD_IMM, OP_ADD_IMM, OP_SUB_IMM, OP_AND_IMM, OP_OR_IMM,
			OP_XOR_IMM}) ? m : dm[m];
		r = v;
		we = 0;
		cyc = 4;
		npc = mpc + 1;
		case (o)
			OP_STORE_W: r = w;
			OP_ADD_W, OP_SUM_MEM, OP_ADD_IMM: r = add(w, v, 0);
			OP_SUMC_W, OP_SUMC_MEM: r = add(w, v, fc);
			// Subtraction adds the complement, so carry high means no borrow.
			OP_SUB_W, OP_SUB_MEM, OP_SUB_IMM: r = add(w, 255 - v, 1);
			OP_SUBB_W, OP_SUBB_MEM: r = add(w, 255 - v, fc);
			OP_BCD_ADJ: begin
				r = w;
				if ((r & 15) > 9 || fhc) r += 6;
				if (((r >> 4) & 15) > 9 || fc || r > 255) begin
					r += 96;
					fc = 1;
				end
				r &= 255;
			end
			OP_STEP_UP, OP_STEP_UP_W: r = (v + 1) & 255;
			OP_STEP_DN, OP_STEP_DN_W: r = (v + 255) & 255;
			OP_AND_W, OP_AND_IMM: r = w & v;
			OP_OR_W, OP_OR_IMM: r = w | v;
			OP_XOR_W, OP_XOR_IMM: r = w ^ v;
			OP_COMPL, OP_COMPL_W: r = 255 - v;
			OP_TURN_R: r = (v >> 1) | ((v & 1) << 7);
			OP_TURN_L: r = ((v << 1) | (v >> 7)) & 255;
			OP_TURN_RC: begin
				r = (v >> 1) | (fc << 7);
				fc = v & 1;
			end
			OP_TURN_LC: begin
				r = ((v << 1) | fc) & 255;
				fc = v >> 7;
			end
			OP_BIT_RAISE: r = v | (1 << b);
			OP_BIT_LOWER: r = v & ~(1 << b);
			OP_SKIP_Z, OP_SKIP_BZ, OP_SKIP_BNZ: begin
				if ((o == OP_SKIP_Z) ? v == 0 : ((v >> b) & 1) == (o == OP_SKIP_BNZ)) begin
					npc = mpc + 2;
					cyc = 8;
				end
			end
			OP_GOTO, OP_SUB_ENTRY: begin
				if (o == OP_SUB_ENTRY) stk.push_back(mpc + 1);
				npc = i[10:0];
				cyc = 8;
			end
			OP_SUB_EXIT: begin
				npc = stk.pop_back();
				cyc = 8;
			end
			OP_TBL_RD: begin
				r = prog[{3'h7, 8'(w)}] & 255;
				cyc = 8;
			end
			default: ;
		endcase
		if (o >= OP_STEP_UP && o <= OP_COMPL_W) fz = (r == 0);
		if (o inside {OP_LOAD_W, OP_LOAD_IMM, OP_ADD_W, OP_ADD_IMM, OP_SUMC_W, OP_SUB_W,
			OP_SUB_IMM, OP_SUBB_W, OP_STEP_UP_W, OP_STEP_DN_W, OP_AND_W, OP_AND_IMM,
			OP_OR_W, OP_OR_IMM, OP_XOR_W, OP_XOR_IMM, OP_COMPL_W}) w = r;
		if (o inside {OP_STORE_W, OP_SUM_MEM, OP_SUMC_MEM, OP_SUB_MEM, OP_SUBB_MEM, OP_BCD_ADJ,
			OP_STEP_UP, OP_STEP_DN, OP_COMPL, OP_TURN_R, OP_TURN_L, OP_TURN_RC, OP_TURN_LC,
			OP_BIT_RAISE, OP_BIT_LOWER, OP_TBL_RD}) begin
			if (m == 2 && o != OP_TBL_RD) begin
				npc = (mpc & 'h700) | r;
				cyc = 8;
			end else begin
				we = 1;
				ma = m;
				md = r;
				dm[m] = r;
			end
		end
	endtask : model

	initial begin
		#(50 * 6000);
		mismatches++;
		stop_test();
	end

	initial begin
		clk = 0;
		rst_n = 0;
		wake = 0;
		seed = 95;
		{fz, fc, fhc, fsr, fsec} = '0;
		foreach (prog[j]) prog[j] = 0;
		for (int p = 0; p < 2; p++) begin
			put(OP_LOAD_IMM, rnd() & 255);
			put(OP_STORE_W, 'h10);
			put(OP_STORE_W, 'h11);
			for (int k = OP_LOAD_W; k <= OP_BIT_LOWER; k++)
				if (k != OP_BCD_ADJ)
					put(mie_op_t'(k), (mie_op_t'(k) inside {OP_LOAD_IMM, OP_ADD_IMM, OP_SUB_IMM,
						OP_AND_IMM, OP_OR_IMM, OP_XOR_IMM}) ? rnd() & 255 : (rnd() & 'h700) | 'h10 | k & 1);
		end
		put(OP_LOAD_IMM, 'h80);
		put(OP_ADD_IMM, 'h80);
		put(OP_SUB_IMM, 1);
		put(OP_LOAD_IMM, 'hFF);
		put(OP_STORE_W, 'h12);
		put(OP_STEP_UP, 'h12);
		put(OP_SKIP_Z, 'h12);
		put(OP_LOAD_IMM, 'hCC);
		put(OP_LOAD_IMM, 'h15);
		put(OP_ADD_IMM, 'h27);
		put(OP_BCD_ADJ, 'h12);
		put(OP_SKIP_Z, 'h12);
		put(OP_SKIP_BZ, 'h012);
		put(OP_LOAD_IMM, 'hEE);
		put(OP_SKIP_BNZ, 'h112);
		put(OP_LOAD_IMM, 'hDD);
		put(OP_SKIP_BZ, 'h112);
		put(OP_SUB_ENTRY, 'h200);
		put(OP_TBL_RD, 'h13);
		put(OP_LOAD_W, 'h13);
		put(OP_LOAD_IMM, 'h80);
		put(OP_STORE_W, 'h02);
		prog['h733] = 18'(rnd());
		pa = 'h200;
		put(OP_LOAD_IMM, 'h33);
		put(OP_SUB_EXIT, 0);
		pa = 'h80;
		put(OP_WDT_CLEAR, 0);
		put(OP_PWR_DOWN, 0);
		put(OP_GOTO, 'h300);
		repeat (20) @(posedge clk);
		#1 check({work_reg, fz_o, fc_o, fhc_o, fsr_o, fsec_o, pwr_dn, wdt_clr, mem_we}, 0);
		check({done, 4'h0, prog_addr}, 0);
		@(posedge clk) rst_n <= 1;
		mpc = 0;
		w = 0;
		first = 1;
		while (mpc != 'h301) begin
			ins = prog[mpc];
			model(ins);
			n = 0;
			if (ins[17:12] == OP_PWR_DOWN) begin
				while (pwr_dn !== 1 && n < 20) begin
					@(posedge clk);
					#1 n++;
				end
				// The core must stay asleep until a wake request arrives.
				repeat (8) begin
					@(posedge clk);
					#1 check(pwr_dn, 1);
				end
				@(posedge clk) wake <= 1;
				n = 0;
				while (pwr_dn !== 0 && n < 20) begin
					@(posedge clk);
					#1 n++;
				end
				check(pwr_dn, 0);
				@(posedge clk) wake <= 0;
				first = 1;
			end else begin
				do begin
					@(posedge clk);
					#1 n++;
				end while (done !== 1 && n < 40);
				if (!first) check(n, cyc);
				first = 0;
				check(work_reg, w);
				check(prog_addr, npc);
				check({fsec_o, fsr_o, fhc_o, fc_o, fz_o}, (fsec << 4) | (fsr << 3) | (fhc << 2) | (fc << 1) | fz);
				check({mem_we, wdt_clr}, (we << 1) | (ins[17:12] == OP_WDT_CLEAR));
				if (we) check({mem_waddr, mem_wdata}, (ma << 8) | md);
			end
			mpc = npc;
		end
		stop_test();
	end
endmodule : tb_top
